/* File: src/usfb_defines.svh */
// register offsets, field positions, reset values and timing counts of the usart frame/baud block
`ifndef USFB_DEFINES_SVH
`define USFB_DEFINES_SVH
`define USFB_AW          8
`define USFB_OFS_CTRL_A  8'h00
`define USFB_OFS_CTRL_B  8'h04
`define USFB_OFS_CTRL_C  8'h08
`define USFB_OFS_BAUD_LO 8'h0c
`define USFB_OFS_BAUD_HI 8'h10
`define USFB_OFS_DATA    8'h14
`define USFB_A_RXFULL    7
`define USFB_A_TXIDLE    6
`define USFB_A_FIFORDY   5
`define USFB_A_FERR      4
`define USFB_A_OVR       3
`define USFB_A_DBL       1
`define USFB_B_RXEN      4
`define USFB_B_TXEN      3
`define USFB_B_SZHI      2
`define USFB_B_RX9       1
`define USFB_B_TX9       0
`define USFB_C_MODE      6
`define USFB_C_SZLO_MSB  2
`define USFB_C_SZLO_LSB  1
`define USFB_C_POL       0
`define USFB_SZLO_RST    2'b11
`define USFB_DIV_RST     12'h000
`define USFB_OS_NORM     5'd16
`define USFB_OS_DBL      5'd8
`define USFB_NB5         4'd5
`define USFB_NB6         4'd6
`define USFB_NB7         4'd7
`define USFB_NB8         4'd8
`define USFB_NB9         4'd9
`define USFB_FIFO_DEPTH  16
`endif

/* File: src/usfb_pkg.sv */
// types shared by the usart frame/baud block
`default_nettype none
package usfb_pkg;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } usfb_tx_e;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } usfb_rx_e;
  typedef struct packed {
    logic       sync_mode;
    logic       polarity;
    logic       dbl;
    logic       rx_en;
    logic       tx_en;
    logic [2:0] char_size;
  } usfb_cfg_s;
endpackage : usfb_pkg
`default_nettype wire

/* File: src/usfb_top.sv */
// usart channel with frame-format and baud-rate configuration, apb slave and transmit fifo
//
// Function
// - rx and tx share one char length: 000..011 give 5..8, 111 gives 9 bits
// - sync, polarity 0: tx changes on rising clock, rx samples falling; 1 swaps
// - one 12-bit divisor sets the bit rate
// - high register low nibble holds divisor top bits, low register the lower eight
// - high register upper nibble reads zero; software writes zeros there
// - writing the low register reloads the prescaler with the full divisor at once
// - divisor changes mid-frame corrupt that frame; change only when idle
// - double speed bit turns the async oversampling ratio from 16 to 8
// - mode select 0 is asynchronous, 1 is synchronous
// - ninth rx bit read before low bits; ninth tx bit written before low bits
`timescale 1ns/1ps
`default_nettype none
`include "usfb_defines.svh"

// ----------------------------------------
// transmit fifo
// ----------------------------------------
module usfb_fifo #(
  parameter int W = 9,
  parameter int D = `USFB_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // fill side
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  // drain side
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q;
  logic          push, pop;

  assign wr_ready = (cnt_q != D[AW:0]);
  assign rd_valid = (cnt_q != '0);
  assign rd_data  = mem[rp_q];
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_q] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : usfb_fifo

// ----------------------------------------
// channel top
// ----------------------------------------
module usfb_top import usfb_pkg::*; #(
  parameter int FIFO_DEPTH = `USFB_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`USFB_AW-1:0] paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // serial line
  input  wire logic                serial_in_pin,
  output logic                     serial_out_pin,
  output logic                     sync_clock_pin
);
  usfb_cfg_s   cfg;
  logic        dbl_q, rx_en_q, tx_en_q, sz_hi_q, tx9_q, mode_q, pol_q;
  logic [1:0]  sz_lo_q;
  logic [3:0]  baud_hi_q;
  logic [7:0]  baud_lo_q;
  logic [11:0] divisor, presc_q;
  logic        tick, launch, sample;
  logic [4:0]  ratio;
  logic [3:0]  nbits;
  logic        acc, wr, rd_data_reg, hit;
  logic [31:0] rdata;
  logic        fifo_wr_ready, fifo_rd_valid, fifo_pop;
  logic [8:0]  fifo_rd_data;
  usfb_tx_e    tx_state_q;
  usfb_rx_e    rx_state_q;
  logic [8:0]  tx_sh_q, rx_sh_q, rx_buf_q;
  logic [3:0]  tx_cnt_q, rx_cnt_q;
  logic [4:0]  tx_os_q, rx_os_q;
  logic        tx_step, rx_step, rx_done;
  logic        rx_full_q, ferr_q, ovr_q;

  assign cfg = '{sync_mode: mode_q, polarity: pol_q, dbl: dbl_q, rx_en: rx_en_q,
                 tx_en: tx_en_q, char_size: {sz_hi_q, sz_lo_q}};

  // ----------------------------------------
  // frame format and rate
  // ----------------------------------------
  always_comb begin
    case (cfg.char_size)
      3'b000:  nbits = `USFB_NB5;
      3'b001:  nbits = `USFB_NB6;
      3'b010:  nbits = `USFB_NB7;
      3'b111:  nbits = `USFB_NB9;
      default: nbits = `USFB_NB8; // reserved codes fall back to eight bits
    endcase
  end

  assign divisor = {baud_hi_q, baud_lo_q};
  assign ratio   = cfg.dbl ? `USFB_OS_DBL : `USFB_OS_NORM;
  assign tick    = (presc_q == `USFB_DIV_RST) && !(wr && paddr == `USFB_OFS_BAUD_LO);
  // the sync clock toggles each prescaler tick; polarity picks which edge launches
  assign launch  = cfg.sync_mode && tick && (sync_clock_pin == cfg.polarity);
  assign sample  = cfg.sync_mode && tick && (sync_clock_pin != cfg.polarity);

  // no guard against mid-frame reloads: software owns the idle check
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      presc_q <= `USFB_DIV_RST;
    end else if (wr && paddr == `USFB_OFS_BAUD_LO) begin
      presc_q <= {baud_hi_q, pwdata[7:0]};
    end else if (tick) begin
      presc_q <= divisor;
    end else begin
      presc_q <= presc_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sync_clock_pin <= 1'b0;
    end else if (!cfg.sync_mode) begin
      sync_clock_pin <= 1'b0;
    end else if (tick) begin
      sync_clock_pin <= !sync_clock_pin;
    end
  end

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  assign acc         = psel && penable;
  assign wr          = acc && pready && pwrite;
  assign rd_data_reg = acc && pready && !pwrite && paddr == `USFB_OFS_DATA;

  always_comb begin
    hit   = 1'b1;
    rdata = '0;
    if (paddr == `USFB_OFS_CTRL_A) begin
      rdata[`USFB_A_RXFULL]  = rx_full_q;
      rdata[`USFB_A_TXIDLE]  = (tx_state_q == TX_IDLE) && !fifo_rd_valid;
      rdata[`USFB_A_FIFORDY] = fifo_wr_ready;
      rdata[`USFB_A_FERR]    = ferr_q;
      rdata[`USFB_A_OVR]     = ovr_q;
      rdata[`USFB_A_DBL]     = dbl_q;
    end else if (paddr == `USFB_OFS_CTRL_B) begin
      rdata[`USFB_B_RXEN] = rx_en_q;
      rdata[`USFB_B_TXEN] = tx_en_q;
      rdata[`USFB_B_SZHI] = sz_hi_q;
      rdata[`USFB_B_RX9]  = rx_buf_q[8];
      rdata[`USFB_B_TX9]  = tx9_q;
    end else if (paddr == `USFB_OFS_CTRL_C) begin
      rdata[`USFB_C_MODE] = mode_q;
      rdata[`USFB_C_SZLO_MSB:`USFB_C_SZLO_LSB] = sz_lo_q;
      rdata[`USFB_C_POL]  = pol_q;
    end else if (paddr == `USFB_OFS_BAUD_LO) begin
      rdata[7:0] = baud_lo_q;
    end else if (paddr == `USFB_OFS_BAUD_HI) begin
      rdata[3:0] = baud_hi_q;
    end else if (paddr == `USFB_OFS_DATA) begin
      rdata[7:0] = rx_buf_q[7:0];
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc && !pready;
      prdata  <= (acc && !pready && !pwrite) ? rdata : '0;
      // a data write into a full fifo is refused rather than stalled
      pslverr <= acc && !pready &&
                 (!hit || (pwrite && paddr == `USFB_OFS_DATA && !fifo_wr_ready));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dbl_q     <= 1'b0;
      rx_en_q   <= 1'b0;
      tx_en_q   <= 1'b0;
      sz_hi_q   <= 1'b0;
      tx9_q     <= 1'b0;
      mode_q    <= 1'b0;
      sz_lo_q   <= `USFB_SZLO_RST;
      pol_q     <= 1'b0;
      baud_hi_q <= '0;
      baud_lo_q <= '0;
    end else if (wr) begin
      if (paddr == `USFB_OFS_CTRL_A) begin
        dbl_q <= pwdata[`USFB_A_DBL];
      end else if (paddr == `USFB_OFS_CTRL_B) begin
        rx_en_q <= pwdata[`USFB_B_RXEN];
        tx_en_q <= pwdata[`USFB_B_TXEN];
        sz_hi_q <= pwdata[`USFB_B_SZHI];
        tx9_q   <= pwdata[`USFB_B_TX9];
      end else if (paddr == `USFB_OFS_CTRL_C) begin
        mode_q  <= pwdata[`USFB_C_MODE];
        sz_lo_q <= pwdata[`USFB_C_SZLO_MSB:`USFB_C_SZLO_LSB];
        pol_q   <= pwdata[`USFB_C_POL];
      end else if (paddr == `USFB_OFS_BAUD_LO) begin
        baud_lo_q <= pwdata[7:0];
      end else if (paddr == `USFB_OFS_BAUD_HI) begin
        baud_hi_q <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  usfb_fifo #(.W(9), .D(FIFO_DEPTH)) u_txf (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .wr_valid (wr && paddr == `USFB_OFS_DATA),
    .wr_ready (fifo_wr_ready),
    .wr_data  ({tx9_q, pwdata[7:0]}),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_pop),
    .rd_data  (fifo_rd_data)
  );

  // async frames start on a tick so the start bit lasts a whole bit time
  assign fifo_pop = (tx_state_q == TX_IDLE) && fifo_rd_valid && cfg.tx_en &&
                    (cfg.sync_mode ? launch : tick);
  assign tx_step  = cfg.sync_mode ? launch : (tick && tx_os_q == ratio - 5'd1);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tx_state_q     <= TX_IDLE;
      serial_out_pin <= 1'b1;
      tx_sh_q        <= '0;
      tx_cnt_q       <= '0;
      tx_os_q        <= '0;
    end else begin
      if (tx_state_q == TX_IDLE) begin
        tx_os_q <= '0;
      end else if (tick) begin
        tx_os_q <= (tx_os_q == ratio - 5'd1) ? 5'd0 : tx_os_q + 5'd1;
      end
      case (tx_state_q)
        TX_IDLE: begin
          serial_out_pin <= 1'b1;
          if (fifo_pop) begin
            tx_sh_q        <= fifo_rd_data;
            serial_out_pin <= 1'b0;
            tx_state_q     <= TX_START;
          end
        end
        TX_START: begin
          if (tx_step) begin
            serial_out_pin <= tx_sh_q[0];
            tx_sh_q        <= tx_sh_q >> 1;
            tx_cnt_q       <= 4'd1;
            tx_state_q     <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_step) begin
            if (tx_cnt_q == nbits) begin
              serial_out_pin <= 1'b1;
              tx_state_q     <= TX_STOP;
            end else begin
              serial_out_pin <= tx_sh_q[0];
              tx_sh_q        <= tx_sh_q >> 1;
              tx_cnt_q       <= tx_cnt_q + 4'd1;
            end
          end
        end
        TX_STOP: begin
          if (tx_step) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign rx_step = cfg.sync_mode ? sample : (tick && rx_os_q == ratio - 5'd1);
  assign rx_done = (rx_state_q == RX_STOP) && rx_step;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_state_q <= RX_IDLE;
      rx_sh_q    <= '0;
      rx_cnt_q   <= '0;
      rx_os_q    <= '0;
    end else begin
      if (tick) begin
        rx_os_q <= (rx_os_q == ratio - 5'd1) ? 5'd0 : rx_os_q + 5'd1;
      end
      case (rx_state_q)
        RX_IDLE: begin
          rx_cnt_q <= '0;
          if (cfg.rx_en && !serial_in_pin) begin
            if (cfg.sync_mode && sample) begin
              rx_sh_q    <= '0;
              rx_state_q <= RX_DATA;
            end else if (!cfg.sync_mode && tick) begin
              // start half way so later samples land mid-bit
              rx_os_q    <= ratio >> 1;
              rx_sh_q    <= '0;
              rx_state_q <= RX_START;
            end
          end
        end
        RX_START: begin
          if (rx_step) begin
            rx_state_q <= serial_in_pin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_step) begin
            rx_sh_q[rx_cnt_q] <= serial_in_pin;
            rx_cnt_q          <= rx_cnt_q + 4'd1;
            if (rx_cnt_q == nbits - 4'd1) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_step) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // a frame landing in the cycle of a data read still sets its flags
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_buf_q  <= '0;
      rx_full_q <= 1'b0;
      ferr_q    <= 1'b0;
      ovr_q     <= 1'b0;
    end else if (!cfg.rx_en) begin
      rx_full_q <= 1'b0;
      ferr_q    <= 1'b0;
      ovr_q     <= 1'b0;
    end else if (rx_done) begin
      rx_buf_q  <= rx_sh_q;
      rx_full_q <= 1'b1;
      ferr_q    <= !serial_in_pin;
      ovr_q     <= rx_full_q && !rd_data_reg;
    end else if (rd_data_reg) begin
      rx_full_q <= 1'b0;
      ferr_q    <= 1'b0;
      ovr_q     <= 1'b0;
    end
  end
endmodule : usfb_top
`default_nettype wire

/* File: tb/usfb_top_assertions.sv */
// port checker for the usart frame/baud block
`timescale 1ns/1ps
`default_nettype none
`include "usfb_defines.svh"
module usfb_top_assertions (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                nrst,
  // apb
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [`USFB_AW-1:0] paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  // serial line
  input wire logic                serial_in_pin,
  input wire logic                serial_out_pin,
  input wire logic                sync_clock_pin
);
  // ----------------------------------------
  // shadow of what software wrote
  // ----------------------------------------
  logic [11:0] div_q;
  logic        dbl_q, mode_q, pol_q, out_q, wr_done;
  int          run_q, bit_t;
  assign wr_done = psel && penable && pready && pwrite;
  assign bit_t   = (dbl_q ? 8 : 16) * (int'(div_q) + 1);
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      div_q  <= 12'h000;
      dbl_q  <= 1'b0;
      mode_q <= 1'b0;
      pol_q  <= 1'b0;
    end else if (wr_done) begin
      if (paddr == `USFB_OFS_BAUD_LO) div_q[7:0] <= pwdata[7:0];
      if (paddr == `USFB_OFS_BAUD_HI) div_q[11:8] <= pwdata[3:0];
      if (paddr == `USFB_OFS_CTRL_A) dbl_q <= pwdata[1];
      if (paddr == `USFB_OFS_CTRL_C) mode_q <= pwdata[6];
      if (paddr == `USFB_OFS_CTRL_C) pol_q <= pwdata[0];
    end
  end
  // length of the present level on the transmit line
  always_ff @(posedge clk_sys) begin
    out_q <= serial_out_pin;
    run_q <= (serial_out_pin != out_q) ? 1 : run_q + 1;
  end
  // cycles since the last sync clock edge, restarted by a low divisor write
  logic        sclk_q, lo_arm_q, lo_wr;
  int          gap_q;
  assign lo_wr = wr_done && paddr == `USFB_OFS_BAUD_LO;
  always_ff @(posedge clk_sys) begin
    sclk_q <= sync_clock_pin;
    if (!nrst) begin
      lo_arm_q <= 1'b0;
      gap_q    <= 0;
    end else if (lo_wr) begin
      lo_arm_q <= mode_q;
      gap_q    <= 0;
    end else if (sync_clock_pin != sclk_q) begin
      lo_arm_q <= 1'b0;
      gap_q    <= 1;
    end else begin
      gap_q <= gap_q + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    penable && !pready ##1 penable && pready;
  endsequence
  sequence rd_s(logic [7:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  AST_APB_ANSWER: assert property (setup_s |=> answer_s)
    else $error("apb answer not in second access cycle");
  AST_LO_RELOAD: assert property (lo_arm_q && $changed(sync_clock_pin) |-> gap_q == int'(div_q) + 1)
    else $error("low divisor write did not reload the prescaler at once");
  AST_LO_READ: assert property (rd_s(`USFB_OFS_BAUD_LO) |-> prdata == {24'h0, div_q[7:0]})
    else $error("low divisor byte reads back wrong");
  AST_HI_READ: assert property (rd_s(`USFB_OFS_BAUD_HI) |-> prdata == {28'h0, div_q[11:8]})
    else $error("high divisor byte reads back wrong");
  AST_RST_OUT: assert property (!$past(nrst) |-> serial_out_pin && !sync_clock_pin && !pready)
    else $error("outputs not idle after reset");
  AST_ASYNC_NOCLK: assert property (!mode_q && !$past(mode_q) && !$past(mode_q, 2) |-> !sync_clock_pin)
    else $error("sync clock moves in async mode");
  AST_SYNC_POL0: assert property (mode_q && !pol_q && $changed(serial_out_pin) |-> $rose(sync_clock_pin))
    else $error("tx changed off the rising sync clock");
  AST_SYNC_POL1: assert property (mode_q && pol_q && $changed(serial_out_pin) |-> $fell(sync_clock_pin))
    else $error("tx changed off the falling sync clock");
  AST_ASYNC_BIT: assert property (!mode_q && $rose(serial_out_pin) |-> run_q % bit_t == 0)
    else $error("async low run is not whole bit times");
endmodule : usfb_top_assertions
bind usfb_top usfb_top_assertions u_chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .sync_clock_pin(sync_clock_pin));
`default_nettype wire

/* File: tb/usfb_peer.sv */
// remote serial peer on the line side of the channel
`timescale 1ns/1ps
`default_nettype none
module usfb_peer (
  // clock
  input  wire logic clk_sys,
  // line
  input  wire logic serial_out_pin,
  input  wire logic sync_clock_pin,
  output var logic  serial_in_pin
);
  // ----------------------------------------
  // frames into and out of the channel
  // ----------------------------------------
  initial serial_in_pin = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input int bt);
    for (int i = -1; i <= n; i++) begin
      serial_in_pin <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[i];
      repeat (bt) @(posedge clk_sys);
    end
  endtask : send
  // samples mid-bit; stop bit is checked so a following start is not missed
  task automatic recv(input int n, input int bt, output logic [8:0] d, output bit ok);
    int t;
    t = 0;
    d = '0;
    while (serial_out_pin !== 1'b0 && t < 3000) begin
      @(posedge clk_sys);
      t++;
    end
    repeat (bt / 2) @(posedge clk_sys);
    for (int i = 0; i <= n; i++) begin
      repeat (bt) @(posedge clk_sys);
      if (i < n) d[i] = serial_out_pin;
    end
    ok = t < 3000 && serial_out_pin === 1'b1;
  endtask : recv
  task automatic recv_sync(input logic pol, input int n, output logic [8:0] d, output bit ok);
    int   k, t;
    logic prev;
    k = -1;
    t = 0;
    d = '0;
    prev = sync_clock_pin;
    while (k < n && t < 3000) begin
      @(posedge clk_sys);
      t++;
      if (sync_clock_pin !== prev && sync_clock_pin === pol) begin
        if (k >= 0) d[k] = serial_out_pin;
        if (k >= 0 || serial_out_pin === 1'b0) k++;
      end
      prev = sync_clock_pin;
    end
    ok = k == n;
  endtask : recv_sync
endmodule : usfb_peer
`default_nettype wire

/* File: tb/test_usart_frame_and_baud_config.sv */
// self-checking bench for the usart frame/baud block
`timescale 1ns/1ps
`default_nettype none
`include "usfb_defines.svh"
module test_usart_frame_and_baud_config;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, serial_in_pin, serial_out_pin, sync_clock_pin, err, dbl;
  logic [31:0] prdata, rd;
  logic [11:0] dv;
  logic [8:0]  got, exp;
  logic [2:0]  sizes [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b111};
  bit          ok;
  int          n, b;
  int          fails = 0;
  int          check_count = 0;
  int          seed = 32'h0dfd;
  always #5 clk_sys = ~clk_sys;
  usfb_top uut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .sync_clock_pin(sync_clock_pin));
  usfb_peer peer (.clk_sys(clk_sys), .serial_out_pin(serial_out_pin), .sync_clock_pin(sync_clock_pin),
    .serial_in_pin(serial_in_pin));
  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  task automatic finish_test;
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (t >= 50) begin
      fails++;
      finish_test();
    end
  endtask : apb
  // waits out any frame tail so the rate never changes mid-transfer
  task automatic cfg(input logic [2:0] sz, input logic db, input logic [11:0] d, input logic sm, input logic pl);
    repeat (64) @(posedge clk_sys);
    apb(1'b1, `USFB_OFS_CTRL_A, {db, 1'b0});
    apb(1'b1, `USFB_OFS_CTRL_B, {27'h3, sz[2], 2'b00});
    apb(1'b1, `USFB_OFS_CTRL_C, {sm, 3'b000, sz[1:0], pl});
    apb(1'b1, `USFB_OFS_BAUD_HI, d[11:8]);
    apb(1'b1, `USFB_OFS_BAUD_LO, d[7:0]);
  endtask : cfg
  function automatic int nbits(input logic [2:0] sz);
    return (sz == 3'b111) ? 9 : 5 + int'(sz[1:0]);
  endfunction : nbits
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(1'b0, `USFB_OFS_CTRL_C, 0);
    chk("ctrl_c reset", rd, 32'h06);
    apb(1'b0, `USFB_OFS_BAUD_LO, 0);
    chk("baud_lo reset", rd, 32'h0);
    apb(1'b0, `USFB_OFS_BAUD_HI, 0);
    chk("baud_hi reset", rd, 32'h0);
    apb(1'b0, 8'h40, 0);
    chk("unmapped error", err, 1);
    repeat (2) begin
      dv = 12'($random(seed));
      apb(1'b1, `USFB_OFS_BAUD_HI, dv[11:8]);
      apb(1'b1, `USFB_OFS_BAUD_LO, dv[7:0]);
      apb(1'b0, `USFB_OFS_BAUD_HI, 0);
      chk("baud_hi", rd, dv[11:8]);
      apb(1'b0, `USFB_OFS_BAUD_LO, 0);
      chk("baud_lo", rd, dv[7:0]);
    end
    // a wide divisor (12'h100) first proves the high register bits set the rate
    foreach (sizes[i]) begin
      dbl = (i == 0) | 1'($random(seed));
      dv = (i == 0) ? 12'h100 : 12'($random(seed)) & 12'h003;
      n = nbits(sizes[i]);
      b = (dbl ? 8 : 16) * (dv + 1);
      cfg(sizes[i], dbl, dv, 1'b0, 1'b0);
      exp = 9'($random(seed)) & 9'((1 << n) - 1);
      apb(1'b1, `USFB_OFS_CTRL_B, {27'h3, sizes[i][2], 1'b0, exp[8]});
      apb(1'b1, `USFB_OFS_DATA, exp[7:0]);
      peer.recv(n, b, got, ok);
      chk("tx frame", {ok, got}, {1'b1, exp});
      exp = 9'($random(seed)) & 9'((1 << n) - 1);
      peer.send(exp, n, b);
      apb(1'b0, `USFB_OFS_CTRL_B, 0);
      if (n == 9) chk("ninth rx bit", rd[1], exp[8]);
      apb(1'b0, `USFB_OFS_DATA, 0);
      chk("rx data", rd, exp[7:0]);
    end
    // transmitter held off so the fifo fills until it refuses
    cfg(3'b011, 1'b0, 12'h000, 1'b0, 1'b0);
    apb(1'b1, `USFB_OFS_CTRL_B, 32'h10);
    for (int k = 0; k <= 16; k++) begin
      apb(1'b1, `USFB_OFS_DATA, k);
      chk("fifo refusal", err, k == 16);
    end
    apb(1'b1, `USFB_OFS_CTRL_B, 32'h18);
    for (int k = 0; k < 16; k++) begin
      peer.recv(8, 16, got, ok);
      chk("fifo drain", {ok, got}, {1'b1, 9'(k)});
    end
    for (int p = 0; p < 2; p++) begin
      dv = 12'($random(seed)) & 12'h003;
      cfg(3'b011, 1'b0, dv, 1'b1, p[0]);
      exp = 9'($random(seed)) & 9'h0ff;
      apb(1'b1, `USFB_OFS_DATA, exp);
      peer.recv_sync(p[0], 8, got, ok);
      chk("sync frame", {ok, got}, {1'b1, exp});
    end
    finish_test();
  end
endmodule : test_usart_frame_and_baud_config
`default_nettype wire
